// File: hdl/sarsc_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - start requests are ignored while a conversion runs
// - busy_n is low for the whole conversion, high when it ends
// - clock_source_select high: shift clock pin is an input from host
// - clock_source_select low: device drives shift clock pin as output
// - internal mode shifts 16-bit word out MSB first during conversion
// - word shifted out is the previous conversion result
// - internal mode emits exactly 16 shift clock pulses per conversion
// - in internal mode each data bit is stable at the rising edge of its pulse and changes with its falling edge
// - in internal mode, after the LSB, data shows tag level captured at conversion start
// - shift clock stays low after 16 pulses until next request
// - shift clock is derived from the internal conversion clock
// - conversion timing supports 200ksps throughput
// - power-down keeps the unread result in the shift register
// - format select low gives two's complement output
// - two's complement: below midscale all ones, midscale all zeros
// - two's complement full scale is 0 followed by fifteen ones
// - result is a 16-bit word of 65536 codes
// - external mode host may shift out during or after conversion
// - format select high gives straight binary output
// - power-down refuses conversion start
module sarsc_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic read_convert,
	input wire logic clock_source_select,
	input wire logic output_format_select,
	input wire logic power_down_in,
	input wire logic tag_in,
	input wire logic serial_shift_clock_in,
	input wire logic [15:0] sar_result,
	output logic serial_shift_clock_out,
	output logic serial_shift_clock_oe_n,
	output logic serial_data,
	output logic busy_n,
	output logic sample_hold
);
	logic [1:0] cs_sync_r;
	logic [1:0] rc_sync_r;
	logic [1:0] ext_sync_r;
	logic [1:0] fmt_sync_r;
	logic [1:0] pd_sync_r;
	logic [1:0] tag_sync_r;
	logic [1:0] sck_sync_r;
	logic sck_prev_r;
	logic [2:0] low_cnt_r;
	logic armed_r;
	sarsc_pkg::sarsc_state_t state_r;
	logic [8:0] conv_cnt_r;
	logic [15:0] shift_r;
	logic [4:0] bits_r;
	logic [3:0] half_r;
	logic tag_r;
	logic start_req;
	logic sck_rise;
	logic int_mode;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cs_sync_r <= 2'h3;
			rc_sync_r <= 2'h3;
			ext_sync_r <= 2'h0;
			fmt_sync_r <= 2'h0;
			pd_sync_r <= 2'h0;
			tag_sync_r <= 2'h0;
			sck_sync_r <= 2'h0;
			sck_prev_r <= 1'h0;
		end else begin
			cs_sync_r <= {cs_sync_r[0], chip_select_n};
			rc_sync_r <= {rc_sync_r[0], read_convert};
			ext_sync_r <= {ext_sync_r[0], clock_source_select};
			fmt_sync_r <= {fmt_sync_r[0], output_format_select};
			pd_sync_r <= {pd_sync_r[0], power_down_in};
			tag_sync_r <= {tag_sync_r[0], tag_in};
			sck_sync_r <= {sck_sync_r[0], serial_shift_clock_in};
			sck_prev_r <= sck_sync_r[1];
		end
	end

	assign int_mode = ~ext_sync_r[1];
	assign sck_rise = sck_sync_r[1] & ~sck_prev_r;

	// qualify the combined low level of chip select and read/convert
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			low_cnt_r <= 3'h0;
			armed_r <= 1'h1;
		end else if (cs_sync_r[1] | rc_sync_r[1]) begin
			low_cnt_r <= 3'h0;
			armed_r <= 1'h1;
		end else if (low_cnt_r < sarsc_pkg::START_CNT) begin
			low_cnt_r <= low_cnt_r + 3'h1;
		end else if (start_req) begin
			armed_r <= 1'h0;
		end
	end

	assign start_req = ~cs_sync_r[1] & ~rc_sync_r[1] & (low_cnt_r >= sarsc_pkg::START_CNT)
		& armed_r & ~pd_sync_r[1] & (state_r == sarsc_pkg::SARSC_IDLE);

	// conversion timer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= sarsc_pkg::SARSC_IDLE;
			conv_cnt_r <= 9'h000;
			busy_n <= 1'h1;
			sample_hold <= 1'h0;
		end else begin
			unique case (state_r)
				sarsc_pkg::SARSC_IDLE: begin
					if (start_req) begin
						state_r <= sarsc_pkg::SARSC_CONV;
						conv_cnt_r <= sarsc_pkg::CONV_CNT;
						busy_n <= 1'h0;
						sample_hold <= 1'h1;
					end
				end
				sarsc_pkg::SARSC_CONV: begin
					if (conv_cnt_r == 9'h001) begin
						state_r <= sarsc_pkg::SARSC_IDLE;
						busy_n <= 1'h1;
						sample_hold <= 1'h0;
					end
					conv_cnt_r <= conv_cnt_r - 9'h001;
				end
				default: begin
					state_r <= sarsc_pkg::SARSC_IDLE;
				end
			endcase
		end
	end

	// output shift register and shift clock generation
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_r <= sarsc_pkg::RESULT_RST;
			bits_r <= 5'h00;
			half_r <= 4'h0;
			tag_r <= 1'h0;
			serial_shift_clock_out <= 1'h0;
			serial_data <= 1'h0;
		end else if (state_r == sarsc_pkg::SARSC_CONV && conv_cnt_r == 9'h001) begin
			// load new result
			shift_r <= fmt_sync_r[1] ? (sar_result ^ sarsc_pkg::SIGN_FLIP) : sar_result;
			serial_shift_clock_out <= 1'h0;
		end else if (start_req) begin
			tag_r <= tag_sync_r[1];
			bits_r <= int_mode ? 5'(sarsc_pkg::BIT_CNT) : 5'h00;
			half_r <= sarsc_pkg::HALF_CNT;
			serial_shift_clock_out <= 1'h0;
			serial_data <= int_mode ? shift_r[15] : serial_data;
		end else if (int_mode && bits_r != 5'h00) begin
			// pulses timed from the conversion clock
			if (half_r == 4'h1) begin
				half_r <= sarsc_pkg::HALF_CNT;
				serial_shift_clock_out <= ~serial_shift_clock_out;
				if (serial_shift_clock_out) begin
					bits_r <= bits_r - 5'h01;
					shift_r <= {shift_r[14:0], 1'h0};
					serial_data <= (bits_r == 5'h01) ? tag_r : shift_r[14];
				end
			end else begin
				half_r <= half_r - 4'h1;
			end
		end else if (!int_mode && sck_rise && !pd_sync_r[1]) begin
			// external clock: host shifts at its own pace
			serial_data <= shift_r[15];
			shift_r <= {shift_r[14:0], tag_sync_r[1]};
		end else begin
			serial_shift_clock_out <= 1'h0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serial_shift_clock_oe_n <= 1'h1;
		end else begin
			serial_shift_clock_oe_n <= ~int_mode;
		end
	end
endmodule

// File: pkg/sarsc_pkg.sv
package sarsc_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned START_LOW_NS = 40;
	localparam int unsigned START_LOW_CYC = (START_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONV_TIME_NS = 2700;
	localparam int unsigned CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
	localparam int unsigned SCLK_HALF_NS = 80;
	localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;
	localparam int unsigned RESULT_W = 16;
	localparam int unsigned BIT_CNT = 16;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] SIGN_FLIP = 16'h8000;
	localparam logic [8:0] CONV_CNT = 9'(CONV_CYC);
	localparam logic [3:0] HALF_CNT = 4'(SCLK_HALF_CYC);
	localparam logic [2:0] START_CNT = 3'(START_LOW_CYC);
	typedef enum logic [1:0] {SARSC_IDLE, SARSC_CONV} sarsc_state_t;
endpackage

// File: verif/sarsc_core_assertions.sv
`timescale 1ns/100ps
module sarsc_core_assertions (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clock_source_select,
	input wire logic power_down_in,
	input wire logic serial_shift_clock_out,
	input wire logic serial_shift_clock_oe_n,
	input wire logic serial_data,
	input wire logic busy_n
);
	logic [8:0] low_r;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			low_r <= 9'h000;
		else
			low_r <= busy_n ? 9'h000 : low_r + 9'h001;
	end
	a_busy_len: assert property ($rose(busy_n) |-> low_r == 9'h10E)
		else $error("busy length");
	a_oe_ext: assert property (clock_source_select [*4] |-> serial_shift_clock_oe_n)
		else $error("pin driven");
	a_oe_int: assert property (!clock_source_select [*4] |-> !serial_shift_clock_oe_n)
		else $error("pin not driven");
	a_clk_idle: assert property (busy_n |-> !serial_shift_clock_out)
		else $error("clock not idle");
	a_pulse_width: assert property ($rose(serial_shift_clock_out) |->
		serial_shift_clock_out [*8] ##1 !serial_shift_clock_out) else $error("pulse width");
	a_data_hold: assert property ($rose(serial_shift_clock_out) |-> $stable(serial_data) [*8])
		else $error("data moved");
	a_first_pulse: assert property ($fell(busy_n) && !serial_shift_clock_oe_n |->
		!serial_shift_clock_out [*8] ##1 serial_shift_clock_out) else $error("first pulse");
	a_pd_block: assert property (power_down_in [*6] ##0 busy_n |=> busy_n)
		else $error("start in power down");
endmodule
bind sarsc_core sarsc_core_assertions u_chk (.core_clk, .rst, .clock_source_select,
	.power_down_in, .serial_shift_clock_out, .serial_shift_clock_oe_n, .serial_data, .busy_n);

// File: verif/sarsc_host_model.sv
`timescale 1ns/100ps
module sarsc_host_model (
	input wire logic go,
	input wire logic serial_data,
	output logic serial_shift_clock_in,
	output logic [16:0] word
);
	initial serial_shift_clock_in = 1'b0;
	always @(posedge go) begin
		repeat (17) begin
			#40 serial_shift_clock_in = 1'b1;
			#40 serial_shift_clock_in = 1'b0;
			word = {word[15:0], serial_data};
		end
	end
endmodule

// File: verif/sarsc_core_bench.sv
`timescale 1ns/100ps
module sarsc_core_bench;
	logic core_clk = 1'b0, rst = 1'b1, chip_select_n = 1'b1, read_convert = 1'b1, go = 1'b0;
	logic clock_source_select = 1'b0, output_format_select = 1'b0, power_down_in = 1'b0;
	logic tag_in = 1'b0, serial_shift_clock_in, serial_data, busy_n, sample_hold;
	logic serial_shift_clock_out, serial_shift_clock_oe_n;
	logic [15:0] sar_result = 16'h0000, rx, prev;
	logic [16:0] word;
	logic [15:0] vals [5] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h8000, 16'h1234};
	int miscompares, cmp_count, pulses, falls;
	sarsc_core u_dut (.core_clk, .rst, .chip_select_n, .read_convert, .clock_source_select,
		.output_format_select, .power_down_in, .tag_in, .serial_shift_clock_in, .sar_result,
		.serial_shift_clock_out, .serial_shift_clock_oe_n, .serial_data, .busy_n, .sample_hold);
	sarsc_host_model u_host (.go, .serial_data, .serial_shift_clock_in, .word);
	task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic strobe();
		@(posedge core_clk);
		chip_select_n <= 1'b0;
		read_convert <= 1'b0;
		repeat (6) @(posedge core_clk);
		chip_select_n <= 1'b1;
		read_convert <= 1'b1;
	endtask
	task automatic wait_busy(logic v);
		for (int k = 0; k < 400 && busy_n !== v; k++)
			@(negedge core_clk);
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge serial_shift_clock_out) begin
		rx = {rx[14:0], serial_data};
		pulses++;
	end
	always @(negedge busy_n) falls++;
	initial forever #5 core_clk = ~core_clk;
	initial begin
		#50000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		prev = sarsc_pkg::RESULT_RST;
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			sar_result <= vals[i];
			output_format_select <= (i > 1);
			tag_in <= i[0];
			pulses = 0;
			strobe();
			wait_busy(1'b0);
			cmp("hold", 16'h0001, 16'(sample_hold));
			strobe();
			wait_busy(1'b1);
			cmp("hold idle", 16'h0000, 16'(sample_hold));
			cmp("word", prev, rx);
			cmp("pulses", 16'h0010, 16'(pulses));
			cmp("tag", 16'(i[0]), 16'(serial_data));
			prev = vals[i] ^ (i > 1 ? sarsc_pkg::SIGN_FLIP : 16'h0000);
		end
		@(posedge core_clk);
		power_down_in <= 1'b1;
		strobe();
		repeat (20) @(posedge core_clk);
		cmp("falls", 16'h0005, 16'(falls));
		power_down_in <= 1'b0;
		clock_source_select <= 1'b1;
		repeat (6) @(posedge core_clk);
		cmp("oe", 16'h0001, 16'(serial_shift_clock_oe_n));
		go <= 1'b1;
		#1500;
		cmp("ext", prev, word[16:1]);
		finish_test();
	end
endmodule
